// >>> hw/jtag_hider.sv
// Scan-chain switch core: own TAP, slave routing and parking, hidden mode.
// Assumes TCK far slower than aclk (at least eight aclk periods per TCK).
// Operation
// [RULE1] Deselected slave TMS high, low if bit set
// [RULE2] Ungate plus low-mode: reset, then park idle
// [RULE3] Host parking sequence uses five TMS-high clocks
// [RULE4] Deselected former reset slave rests in idle
// [RULE5] Included slave TRST follows switch TRST input
// [RULE6] Excluded slave TRST high unless reset bit
// [RULE7] Hidden mode optional; removes own TAP path
// [RULE8] Hidden TAP still tracks states and TDI
// [RULE9] Hidden mode forces instruction to bypass
// [RULE10] Writing 0x0001 schedules hidden mode activation
// [RULE11] Changes apply after eight idle TCK cycles
// [RULE12] Shift-IR TDI compared against seven-bit key
// [RULE13] Key starts 0x40, shifts, XOR 0xD5, 128
// [RULE14] Mismatch reloads key generator to start
// [RULE15] Host sends key bytes LSB first
// [RULE16] Complete key keeps exit scheduled irrevocably
// [RULE17] Exit ends hidden mode, excludes all slaves
// [RULE18] Bit pairs: 00 keep, 01 set, else clear
// [RULE19] Control word: group in 15..12, six pairs
// [RULE20] Deselected TCK low unless clock-pass bit
// [RULE21] Key generator advances only in Shift-IR
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module jtag_hider
	import jtag_hider_pkg::*;
#(
	parameter bit HIDDEN_SUPPORT = 1'b1
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic jtag_tck, // Probe TCK
	input wire logic jtag_tms, // Probe TMS
	input wire logic jtag_tdi, // Probe TDI
	input wire logic jtag_trst_n, // Probe TRST, active low
	output logic jtag_tdo, // Chain output to probe
	output logic [NUM_SLAVES-1:0] slave_tck, // Per-slave TCK
	output logic [NUM_SLAVES-1:0] slave_tms, // Per-slave TMS
	output logic [NUM_SLAVES-1:0] slave_tdi, // Per-slave TDI
	output logic [NUM_SLAVES-1:0] slave_trst_n, // Per-slave TRST, active low
	input wire logic [NUM_SLAVES-1:0] slave_tdo // Per-slave TDO
);

	logic tck_s, tms_s, tdi_s, trst_n_s, tck_q_r, tck_rise, tck_fall;
	logic [NUM_SLAVES-1:0] slave_tdo_s;
	tap_state_t state_r, state_nxt;
	logic [3:0] ir_r, ir_sh_r;
	logic bypass_r, sw_out_r;
	logic [3:0] rti_cnt_r;
	logic apply_arm_r, apply_now, exit_now;
	logic [6:0] key_r, key_nxt, key_cnt_r;
	logic [7:0] key_shift;
	logic key_done_r, hidden_r, hidden_pend_r;
	logic [NUM_SLAVES-1:0] sel_pend_r, ungate_pend_r, low_pend_r, trst_pend_r;
	logic [NUM_SLAVES-1:0] sel_act_r, ungate_act_r, low_act_r, trst_act_r;
	logic [NUM_SLAVES:0] chain;
	logic aw_got_r, w_got_r, do_write;
	logic [AXI_ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [31:0] rd_data;
	logic [1:0] rd_resp;
	logic [1:0] wr_resp;

	// Pins from the probe and slaves are asynchronous to aclk
	pin_sync3 #(.W(4), .INIT(PIN_INIT)) u_sync_probe (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({jtag_trst_n, jtag_tms, jtag_tdi, jtag_tck}),
		.q({trst_n_s, tms_s, tdi_s, tck_s})
	);
	pin_sync3 #(.W(NUM_SLAVES), .INIT('0)) u_sync_tdo (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(slave_tdo),
		.q(slave_tdo_s)
	);

	// TCK edge finder
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tck_q_r <= 1'b0;
		end else begin
			tck_q_r <= tck_s;
		end
	end
	assign tck_rise = tck_s & ~tck_q_r;
	assign tck_fall = ~tck_s & tck_q_r;

	// Standard TAP transitions, kept even while hidden
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TLR: state_nxt = tms_s ? TLR : RTI;
			RTI: state_nxt = tms_s ? SEL_DR : RTI;
			SEL_DR: state_nxt = tms_s ? SEL_IR : CAP_DR;
			CAP_DR: state_nxt = tms_s ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: state_nxt = tms_s ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: state_nxt = tms_s ? UPD_DR : PAUSE_DR;
			PAUSE_DR: state_nxt = tms_s ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: state_nxt = tms_s ? UPD_DR : SHIFT_DR;
			UPD_DR: state_nxt = tms_s ? SEL_DR : RTI;
			SEL_IR: state_nxt = tms_s ? TLR : CAP_IR;
			CAP_IR: state_nxt = tms_s ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: state_nxt = tms_s ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: state_nxt = tms_s ? UPD_IR : PAUSE_IR;
			PAUSE_IR: state_nxt = tms_s ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: state_nxt = tms_s ? UPD_IR : SHIFT_IR;
			UPD_IR: state_nxt = tms_s ? SEL_DR : RTI;
			default: state_nxt = TLR;
		endcase
	end

	// State register; TRST forces reset asynchronously to TCK
	always_ff @(posedge aclk) begin
		if (!aresetn || !trst_n_s) begin
			state_r <= TLR;
		end else if (tck_rise) begin
			state_r <= state_nxt; // [RULE8]
		end
	end

	// Instruction and bypass registers; hidden mode pins IR to bypass
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir_r <= IR_BYPASS;
			ir_sh_r <= IR_CAPTURE;
			bypass_r <= 1'b0;
		end else begin
			if (hidden_r) begin
				ir_r <= IR_BYPASS; // [RULE9]
			end else if (state_r == TLR) begin
				ir_r <= IR_BYPASS;
			end else if (tck_fall && state_r == UPD_IR) begin
				ir_r <= ir_sh_r;
			end
			if (tck_rise) begin
				if (state_r == CAP_IR) begin
					ir_sh_r <= IR_CAPTURE;
				end else if (state_r == SHIFT_IR) begin
					ir_sh_r <= {tdi_s, ir_sh_r[3:1]}; // [RULE8]
				end
				if (state_r == CAP_DR) begin
					bypass_r <= 1'b0;
				end else if (state_r == SHIFT_DR) begin
					bypass_r <= tdi_s;
				end
			end
		end
	end

	// Own TDO bit changes on the falling TCK edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_out_r <= 1'b0;
		end else if (tck_fall) begin
			sw_out_r <= (state_r == SHIFT_IR) ? ir_sh_r[0] : bypass_r;
		end
	end

	// Idle dwell counter; saturates so one stay applies once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rti_cnt_r <= 4'h0;
			apply_arm_r <= 1'b0;
		end else begin
			if (tck_rise) begin
				if (state_r != RTI) begin
					rti_cnt_r <= 4'h0;
				end else if (rti_cnt_r != RTI_APPLY_CYCLES) begin
					rti_cnt_r <= rti_cnt_r + 4'h1;
				end
			end
			if (tck_rise && state_r == RTI && rti_cnt_r == RTI_APPLY_CYCLES - 4'h1) begin
				apply_arm_r <= 1'b1; // [RULE11]
			end else if (apply_now) begin
				apply_arm_r <= 1'b0;
			end
		end
	end
	// Apply after the falling edge so slaves have seen their idle clocks
	assign apply_now = apply_arm_r & tck_fall; // [RULE4]
	assign exit_now = apply_now & hidden_r & key_done_r;

	// Exit key generator: next value of the seven-bit shifter
	assign key_shift = {key_r, 1'b0};
	assign key_nxt = key_shift[7] ? (key_shift[6:0] ^ KEY_POLY[6:0]) : key_shift[6:0]; // [RULE13]

	// Key watcher, stepping only on Shift-IR clocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_r <= KEY_INIT;
			key_cnt_r <= 7'h00;
			key_done_r <= 1'b0;
		end else begin
			if (tck_rise && state_r == SHIFT_IR && hidden_r) begin // [RULE21]
				if (tdi_s != key_r[6]) begin // [RULE12]
					key_r <= KEY_INIT; // [RULE14]
					key_cnt_r <= 7'h00;
				end else begin
					key_r <= key_nxt;
					key_cnt_r <= key_cnt_r + 7'h01;
					if (key_cnt_r == KEY_LAST) begin
						key_done_r <= 1'b1; // [RULE16]
					end
				end
			end
			if (exit_now) begin
				key_done_r <= 1'b0;
			end
		end
	end

	// Set/clear pair decode for eight control bits
	function automatic logic [NUM_SLAVES-1:0] set_clear(input logic [NUM_SLAVES-1:0] cur,
			input logic [15:0] d);
		logic [NUM_SLAVES-1:0] res;
		res = cur;
		for (int i = 0; i < NUM_SLAVES; i++) begin
			if (d[2*i+1]) begin
				res[i] = 1'b0; // [RULE18]
			end else if (d[2*i]) begin
				res[i] = 1'b1;
			end
		end
		return res;
	endfunction

	// Pending control bits; a write in the exit cycle wins over the exit clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_pend_r <= '0;
			ungate_pend_r <= '0;
			low_pend_r <= '0;
			trst_pend_r <= '0;
			hidden_pend_r <= 1'b0;
		end else begin
			if (exit_now) begin
				sel_pend_r <= '0; // [RULE17]
				hidden_pend_r <= 1'b0;
			end
			if (do_write) begin
				if (aw_addr_r == OFF_SELECT) begin
					sel_pend_r <= set_clear(exit_now ? '0 : sel_pend_r, w_data_r[15:0]);
				end else if (aw_addr_r == OFF_UNGATE) begin
					ungate_pend_r <= set_clear(ungate_pend_r, w_data_r[15:0]);
				end else if (aw_addr_r == OFF_TMS_LOW) begin
					low_pend_r <= set_clear(low_pend_r, w_data_r[15:0]);
				end else if (aw_addr_r == OFF_TRST_ENA) begin
					trst_pend_r <= set_clear(trst_pend_r, w_data_r[15:0]);
				end else if (aw_addr_r == OFF_GLOBAL_CTRL
						&& w_data_r[15:CTRL_GROUP_LSB] == HIDE_GROUP) begin // [RULE19]
					if (w_data_r[HIDE_PAIR_LSB+1]) begin
						hidden_pend_r <= 1'b0;
					end else if (w_data_r[HIDE_PAIR_LSB]) begin
						hidden_pend_r <= HIDDEN_SUPPORT; // [RULE10]
					end
				end
			end
		end
	end

	// Active configuration, switched together after the idle dwell
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_act_r <= '0;
			ungate_act_r <= '0;
			low_act_r <= '0;
			trst_act_r <= '0;
			hidden_r <= 1'b0;
		end else if (apply_now) begin
			ungate_act_r <= ungate_pend_r; // [RULE11]
			low_act_r <= low_pend_r;
			trst_act_r <= trst_pend_r;
			if (exit_now) begin
				sel_act_r <= '0; // [RULE17]
				hidden_r <= 1'b0;
			end else begin
				sel_act_r <= sel_pend_r;
				hidden_r <= hidden_pend_r & HIDDEN_SUPPORT; // [RULE7]
			end
		end
	end

	// Data path: own TAP, or straight TDI when hidden, then included slaves
	assign chain[0] = hidden_r ? tdi_s : sw_out_r; // [RULE7]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			jtag_tdo <= 1'b0;
		end else begin
			jtag_tdo <= chain[NUM_SLAVES];
		end
	end

	// Per-slave routing, clock gating, TMS parking and TRST
	for (genvar g = 0; g < NUM_SLAVES; g++) begin : g_slave
		logic [2:0] park_cnt_r;
		assign chain[g+1] = sel_act_r[g] ? slave_tdo_s[g] : chain[g];

		// Counts forwarded clocks with TMS high while parking
		always_ff @(posedge aclk) begin
			if (!aresetn || apply_now) begin
				park_cnt_r <= 3'h0;
			end else if (tck_rise && !sel_act_r[g] && ungate_act_r[g]
					&& park_cnt_r != PARK_TMS_HIGH_CYCLES) begin
				park_cnt_r <= park_cnt_r + 3'h1;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				slave_tck[g] <= 1'b0;
				slave_tms[g] <= 1'b1;
				slave_tdi[g] <= 1'b0;
				slave_trst_n[g] <= 1'b1;
			end else begin
				slave_tdi[g] <= chain[g];
				if (sel_act_r[g]) begin
					slave_tck[g] <= tck_s;
					slave_tms[g] <= tms_s;
					slave_trst_n[g] <= trst_n_s; // [RULE5]
				end else begin
					slave_tck[g] <= ungate_act_r[g] & tck_s; // [RULE20]
					if (!low_act_r[g]) begin
						slave_tms[g] <= 1'b1; // [RULE1]
					end else begin
						// High for five clocks reaches reset, then low parks in idle
						slave_tms[g] <= ungate_act_r[g]
							&& park_cnt_r != PARK_TMS_HIGH_CYCLES; // [RULE2]
					end
					slave_trst_n[g] <= ~trst_act_r[g]; // [RULE6]
				end
			end
		end
	end

	// AXI4-Lite write: address and data taken in either order
	assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
	assign wr_resp = (aw_addr_r == OFF_SELECT || aw_addr_r == OFF_UNGATE
		|| aw_addr_r == OFF_TMS_LOW || aw_addr_r == OFF_TRST_ENA
		|| aw_addr_r == OFF_GLOBAL_CTRL) ? RESP_OKAY : RESP_SLVERR;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[AXI_ADDR_W-1:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				// Unstrobed lanes become 00 pairs, which leave bits alone
				w_data_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_resp;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Spread an eight-bit control vector onto the even bits
	function automatic logic [31:0] even_bits(input logic [NUM_SLAVES-1:0] v);
		logic [31:0] res;
		res = 32'h0000_0000;
		for (int i = 0; i < NUM_SLAVES; i++) begin
			res[2*i] = v[i];
		end
		return res;
	endfunction

	// Read decode
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_resp = RESP_OKAY;
		if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00} == OFF_CONFIG) begin
			rd_data = CONFIG_VALUE;
		end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00} == OFF_SELECT) begin
			rd_data = even_bits(sel_pend_r);
		end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00} == OFF_UNGATE) begin
			rd_data = even_bits(ungate_pend_r);
		end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00} == OFF_TMS_LOW) begin
			rd_data = even_bits(low_pend_r);
		end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00} == OFF_TRST_ENA) begin
			rd_data = even_bits(trst_pend_r);
		end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00} == OFF_GLOBAL_CTRL) begin
			rd_data[HIDE_PAIR_LSB] = hidden_pend_r;
		end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'b00} == OFF_STATUS) begin
			rd_data[NUM_SLAVES-1:0] = sel_act_r;
			rd_data[STATUS_HIDDEN_BIT] = hidden_r;
			rd_data[STATUS_PEND_BIT] = hidden_pend_r;
			rd_data[STATUS_KEY_BIT] = key_done_r;
		end else begin
			rd_resp = RESP_SLVERR;
		end
	end

	// AXI4-Lite read: one outstanding, answered the cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_resp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// >>> hw/jtag_hider_pkg.sv
// Shared constants for the scan-chain switch: register map, control word
// layout, key generator values and the TAP state encoding.
// Assumes a 32-bit AXI4-Lite slave port and eight downstream slave TAPs.
package jtag_hider_pkg;

	localparam int NUM_SLAVES = 8;
	localparam int AXI_ADDR_W = 8;

	// Byte offsets of the software-visible words
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_SELECT = 8'h04;
	localparam logic [7:0] OFF_UNGATE = 8'h0C;
	localparam logic [7:0] OFF_TMS_LOW = 8'h10;
	localparam logic [7:0] OFF_TRST_ENA = 8'h14;
	localparam logic [7:0] OFF_GLOBAL_CTRL = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;

	// Read-only configuration word: slave count, readback, ungate, tms-low, trst-ena
	localparam logic [31:0] CONFIG_VALUE = 32'h0000_0E88;

	// Global control word layout
	localparam int CTRL_GROUP_LSB = 12;
	localparam logic [3:0] HIDE_GROUP = 4'h0;
	localparam int HIDE_PAIR_LSB = 0;

	// Status word bit positions
	localparam int STATUS_HIDDEN_BIT = 8;
	localparam int STATUS_PEND_BIT = 9;
	localparam int STATUS_KEY_BIT = 10;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing counts in TCK cycles
	localparam logic [3:0] RTI_APPLY_CYCLES = 4'h8;
	localparam logic [2:0] PARK_TMS_HIGH_CYCLES = 3'h5;

	// Exit key generator
	localparam logic [6:0] KEY_INIT = 7'h40;
	localparam logic [7:0] KEY_POLY = 8'hD5;
	localparam logic [6:0] KEY_LAST = 7'h7F;

	// Instruction register
	localparam logic [3:0] IR_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// Pin reset levels
	localparam logic [3:0] PIN_INIT = 4'h6;

	typedef enum logic [15:0] {
		TLR = 16'h0001,
		RTI = 16'h0002,
		SEL_DR = 16'h0004,
		CAP_DR = 16'h0008,
		SHIFT_DR = 16'h0010,
		EXIT1_DR = 16'h0020,
		PAUSE_DR = 16'h0040,
		EXIT2_DR = 16'h0080,
		UPD_DR = 16'h0100,
		SEL_IR = 16'h0200,
		CAP_IR = 16'h0400,
		SHIFT_IR = 16'h0800,
		EXIT1_IR = 16'h1000,
		PAUSE_IR = 16'h2000,
		EXIT2_IR = 16'h4000,
		UPD_IR = 16'h8000
	} tap_state_t;

endpackage

// >>> hw/pin_sync3.sv
// Three-stage synchroniser for pins from outside the aclk domain.
// The output moves only once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [W-1:0] d, // Asynchronous pin levels
	output logic [W-1:0] q // Filtered, synchronised levels
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// First stage feeds only the second one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Accept a change per bit only when the late stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= INIT;
		end else begin
			q <= (q & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
		end
	end

endmodule
`default_nettype wire

// >>> tb/jtag_probe.sv
// JTAG probe model: drives TCK, TMS, TDI and TRST with a 180 ns TCK period.
// Assumes the bench's 20 ns aclk; TCK stands still low between frames.
`timescale 1ns/1ns
`default_nettype none
module jtag_probe (
	input wire logic aclk, // Bench clock
	output logic tck, // Probe TCK
	output logic tms, // Probe TMS
	output logic tdi, // Probe TDI
	output logic trst_n // Probe TRST, active low
);
	// Idle levels; TMS high keeps every TAP in reset when clocked
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b1;
	end
	// One TCK period
	task automatic clk(input logic m, input logic d);
		@(posedge aclk);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge aclk);
		tck <= 1'b1;
		repeat (4) @(posedge aclk);
		tck <= 1'b0;
	endtask
	// Reset pin changes only between frames
	task automatic set_trst(input logic v);
		@(posedge aclk);
		trst_n <= v;
	endtask
endmodule
`default_nettype wire

// >>> tb/jtag_hider_chk.sv
// Port checks of the switch.
// Assumes TCK rests low between frames.
`timescale 1ns/1ns
`default_nettype none
module jtag_hider_chk
	import jtag_hider_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic [1:0] s_axi_rresp, // Read response
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic jtag_tck, // Probe TCK
	input wire logic [NUM_SLAVES-1:0] slave_tck, // Per-slave TCK
	input wire logic [NUM_SLAVES-1:0] slave_tms // Per-slave TMS
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Probe TCK low-time counter
	logic [3:0] tck_low_r;
	always_ff @(posedge aclk) begin
		if (!aresetn || jtag_tck)
			tck_low_r <= 4'h0;
		else if (tck_low_r != 4'hF)
			tck_low_r <= tck_low_r + 4'h1;
	end
	sequence aw_go;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence w_go;
		s_axi_wvalid && s_axi_wready;
	endsequence
	a_reset_pins: assert property ($rose(aresetn) |-> slave_tck == '0 && slave_tms == '1)
		else $error("slave pins not at idle levels after reset");
	a_tck_rest: assert property (tck_low_r == 4'hF |-> slave_tck == '0)
		else $error("slave clock moved while probe clock rests");
	a_write_ans: assert property (aw_go and w_go |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken before response");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	a_read_ans: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data missing");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before ready");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("error read returned data");
endmodule
bind jtag_hider jtag_hider_chk jtag_hider_chk_inst (.*);
`default_nettype wire

// >>> tb/jtag_hider_tb.sv
// Bench of the scan-chain switch.
// Assumes the checker binds itself.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module jtag_hider_tb
	import jtag_hider_pkg::*;
;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, tck, tms, tdi, trst_n, tdo;
	logic [7:0] awaddr, araddr, s_tck, s_tms, s_tdi, s_trst_n, s_tdo, seen_tck, seen_hi;
	logic [7:0] sel, tl, ug, te;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, r;
	logic [3:0] wstrb;
	logic [127:0] key;
	int n_fail, samples_checked;
	jtag_hider jtag_hider_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .jtag_tck(tck), .jtag_tms(tms), .jtag_tdi(tdi),
		.jtag_trst_n(trst_n), .jtag_tdo(tdo), .slave_tck(s_tck), .slave_tms(s_tms),
		.slave_tdi(s_tdi), .slave_trst_n(s_trst_n), .slave_tdo(s_tdo));
	jtag_probe jtag_probe_inst (.aclk(aclk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
	// Clock, 20 ns
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// Random slave TDO each cycle
	always @(posedge aclk) begin
		s_tdo <= 8'($urandom);
		seen_tck <= seen_tck | s_tck;
		seen_hi <= seen_hi | (s_tck & s_tms);
	end
	task automatic finish_test();
		$display("Checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic hang();
		n_fail++;
		$display("ERROR handshake exp answer got none");
		finish_test();
	endtask
	// Write; AW and W together
	task automatic axi_w(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
		int k;
		logic ga, gw, gb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(negedge aclk);
			ga = awvalid && awready;
			gw = wvalid && wready;
			gb = bvalid;
			rsp = bresp;
			@(posedge aclk);
			if (ga)
				awvalid <= 1'b0;
			if (gw)
				wvalid <= 1'b0;
			if (gb) begin
				bready <= 1'b0;
				break;
			end
		end
		if (k == 200)
			hang();
	endtask
	// Read; rready a cycle late
	task automatic axi_r(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
		int k;
		logic ga, gr, acc;
		acc = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(negedge aclk);
			ga = arvalid && arready;
			gr = rvalid && rready;
			d = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ga) begin
				arvalid <= 1'b0;
				acc = 1'b1;
			end else if (acc)
				rready <= 1'b1;
			if (gr) begin
				rready <= 1'b0;
				break;
			end
		end
		if (k == 200)
			hang();
	endtask
	// TMS-high lead, idle clocks, settle
	task automatic go_idle(input int lead, input int n);
		repeat (lead) jtag_probe_inst.clk(1'b1, 1'b0);
		repeat (n) jtag_probe_inst.clk(1'b0, 1'b0);
		repeat (16) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic shift(input logic [127:0] b, input int n);
		for (int j = 0; j < n; j++)
			jtag_probe_inst.clk(1'b0, b[j]);
	endtask
	function automatic logic [7:0] pairs(input logic [7:0] cur, input logic [15:0] w);
		for (int k = 0; k < 8; k++)
			if (w[2*k+:2] != 2'b00)
				cur[k] = (w[2*k+:2] == 2'b01);
		return cur;
	endfunction
	function automatic logic [7:0] ev(input logic [31:0] w);
		for (int k = 0; k < 8; k++)
			ev[k] = w[2*k];
	endfunction
	function automatic logic [127:0] make_key();
		logic [7:0] f;
		f = 8'h40;
		for (int k = 0; k < 128; k++) begin
			make_key[k] = f[6];
			f = f << 1;
			if (f[7])
				f = f ^ 8'hD5;
		end
	endfunction
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{s_tdo, seen_tck, seen_hi, n_fail, samples_checked} = '0;
		wstrb = 4'hF;
		void'($urandom(12));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`CHK("rst_tms", 8'hFF, s_tms)
		`CHK("rst_trst", 8'hFF, s_trst_n)
		axi_r(OFF_CONFIG, v, r);
		`CHK("config", CONFIG_VALUE, v)
		axi_r(8'h3C, v, r);
		`CHK("unmapped", RESP_SLVERR, r)
		axi_w(OFF_CONFIG, 32'h0000_FFFF, r);
		`CHK("ro_write", RESP_SLVERR, r)
		$display("TEST reset_map done");
		// Two writes stacked before any idle; slave 0 set as a corner
		sel = 8'h00;
		for (int t = 0; t < 2; t++) begin
			v = {16'h0000, 16'($urandom)};
			v[1:0] = 2'b01;
			sel = pairs(sel, v[15:0]);
			axi_w(OFF_SELECT, v, r);
		end
		go_idle(3, 7);
		axi_r(OFF_STATUS, v, r);
		`CHK("short_idle", 8'h00, v[7:0])
		axi_r(OFF_SELECT, v, r);
		`CHK("sel_pend", sel, ev(v))
		go_idle(3, 11);
		axi_r(OFF_STATUS, v, r);
		`CHK("sel_active", sel, v[7:0])
		jtag_probe_inst.set_trst(1'b0);
		repeat (10) @(negedge aclk);
		`CHK("trst_incl", ~sel, s_trst_n)
		jtag_probe_inst.set_trst(1'b1);
		$display("TEST select done");
		v = {16'h0000, 16'($urandom)};
		te = pairs(8'h00, v[15:0]);
		axi_w(OFF_TRST_ENA, v, r);
		v = {16'h0000, 16'($urandom)};
		tl = pairs(8'h00, v[15:0]);
		axi_w(OFF_TMS_LOW, v, r);
		v = {16'h0000, 16'($urandom)};
		ug = pairs(8'h00, v[15:0]);
		axi_w(OFF_UNGATE, v, r);
		seen_hi = '0;
		go_idle(3, 11);
		`CHK("trst_excl", ~(te & ~sel), s_trst_n)
		`CHK("park_tms_hi", ug & ~sel, seen_hi & ~sel)
		seen_tck = '0;
		go_idle(0, 6);
		`CHK("park_tms", ~sel & ~tl, s_tms)
		`CHK("clock_pass", sel | ug, seen_tck)
		$display("TEST park done");
		axi_w(OFF_GLOBAL_CTRL, 32'h0000_0001, r);
		axi_r(OFF_GLOBAL_CTRL, v, r);
		`CHK("hide_pend", 1'b1, v[0])
		axi_r(OFF_STATUS, v, r);
		`CHK("hide_early", 1'b0, v[STATUS_HIDDEN_BIT])
		go_idle(3, 11);
		axi_r(OFF_STATUS, v, r);
		`CHK("hidden_on", 1'b1, v[STATUS_HIDDEN_BIT])
		key = make_key();
		`CHK("key_ends", 16'h81b7, {key[127:120], key[7:0]})
		// Into Shift-IR: junk, zero byte, damaged key
		repeat (2) jtag_probe_inst.clk(1'b1, 1'b0);
		repeat (2) jtag_probe_inst.clk(1'b0, 1'b0);
		shift(128'($urandom), 8);
		shift(128'h0, 8);
		shift(key ^ (128'h1 << 70), 128);
		axi_r(OFF_STATUS, v, r);
		`CHK("key_broken", 1'b0, v[STATUS_KEY_BIT])
		shift(128'h0, 8);
		shift(key, 128);
		axi_r(OFF_STATUS, v, r);
		`CHK("key_done", 1'b1, v[STATUS_KEY_BIT])
		shift('1, 16);
		axi_r(OFF_STATUS, v, r);
		`CHK("key_kept", 2'b11, {v[STATUS_KEY_BIT], v[STATUS_HIDDEN_BIT]})
		jtag_probe_inst.clk(1'b1, 1'b1);
		jtag_probe_inst.clk(1'b1, 1'b0);
		go_idle(0, 11);
		axi_r(OFF_STATUS, v, r);
		`CHK("hidden_off", 9'h000, v[8:0])
		axi_r(OFF_SELECT, v, r);
		`CHK("sel_cleared", 8'h00, ev(v))
		$display("TEST hidden done");
		finish_test();
	end
endmodule
`default_nettype wire
